// >>> hdl/iscol_top.sv
// Interrupt status collector: event latching, enable mask and register access
// Functional notes
// - Status word at 58h; writing one clears a flag, zero leaves it.
// - Bit 31 set while software trigger enable high; cleared by writing one.
// - Bit 25 set when stop-transmit requested and transmitter halted.
// - Bit 24 set when the receive engine halts.
// - Bit 23 set when drop counter goes 7FFFFFFFh to 80000000h.
// - Bit 21 set when a completion-marked transmit buffer is loaded.
// - Bit 20 set when programmed receive DMA length has been drained.
// - Bit 19 set when the timer wraps from zero to FFFFh.
// - Bit 18 is read-only and mirrors the transceiver event; writes ignored.
// - Bit 17 set on a detected power management event.
// - Power flag works with pin disabled, clears on write, never held off.
// - Power event does not wake; any write to byte test register wakes.
// - Bit 16 set when the transmit status FIFO overflows.
// - Bit 15 set when an oversize frame trips the receive watchdog.
// - Bit 14 on receive error, bit 13 on transmit error.
// - Bit 10 set on a transmit data write while that FIFO is full.
// - Bit 9 set while transmit free space exceeds the programmed level.
// - Bit 8 set when the transmit status FIFO is full.
// - Bit 7 set when transmit status occupancy reaches programmed level.
// - Bit 6 set each time a received frame is dropped.
// - Bit 4 on receive status FIFO full, bit 3 on its level reached.
// - Bits 2 to 0 latch pin events; each clears by writing one.
// - Flags record events regardless of the enable mask.
// - Master interrupt high whenever any enabled flag is set.
`timescale 1ns/1ps
module iscol_top
   import iscol_pkg::*;
#(
   parameter int TX_FREE_W = 8,
   parameter int LEVEL_W   = 8
)
(
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_rst_b,
   input  wire iscol_bus_req_t       i_bus,
   input  wire iscol_events_t        i_evt,
   input  wire logic                 i_sw_trigger_en,
   input  wire logic                 i_stop_tx_req,
   input  wire logic                 i_drop_cnt_inc,
   input  wire logic [31:0]          i_drop_cnt,
   input  wire logic                 i_timer_dec,
   input  wire logic [15:0]          i_timer_cnt,
   input  wire logic                 i_phy_event,
   input  wire logic [TX_FREE_W-1:0] i_tx_free_blocks,
   input  wire logic [TX_FREE_W-1:0] i_tx_free_level,
   input  wire logic [LEVEL_W-1:0]   i_tx_status_used,
   input  wire logic [LEVEL_W-1:0]   i_tx_status_level,
   input  wire logic [LEVEL_W-1:0]   i_rx_status_used,
   input  wire logic [LEVEL_W-1:0]   i_rx_status_level,
   input  wire logic                 i_asleep,
   output logic [31:0]               o_rdata,
   output logic [31:0]               o_status,
   output logic                      o_master_irq,
   output logic                      o_wake
);

   if (TX_FREE_W < 1 || TX_FREE_W > 16 || LEVEL_W < 1 || LEVEL_W > 16)
   begin : g_param_check
      $error("iscol_top: level widths must lie in 1..16");
   end

   logic [31:0] set_vec;
   logic [31:0] flag_vec;
   logic [31:0] enable_q;
   logic        wr_status;
   logic        wr_enable;
   logic        wr_byte_test;
   logic        tx_lvl_hit_q;
   logic        rx_lvl_hit_q;
   logic        tx_lvl_hit_d;
   logic        rx_lvl_hit_d;

   assign wr_status    = i_bus.wr && (i_bus.addr == ISCOL_OFS_STATUS);
   assign wr_enable    = i_bus.wr && (i_bus.addr == ISCOL_OFS_ENABLE);
   assign wr_byte_test = i_bus.wr && (i_bus.addr == ISCOL_OFS_BYTE_TEST);

   // Level events fire on reaching the level, not on every cycle above it
   assign tx_lvl_hit_d = (i_tx_status_used >= i_tx_status_level);
   assign rx_lvl_hit_d = (i_rx_status_used >= i_rx_status_level);

   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         tx_lvl_hit_q <= 1'b0;
         rx_lvl_hit_q <= 1'b0;
      end
      else
      begin
         tx_lvl_hit_q <= tx_lvl_hit_d;
         rx_lvl_hit_q <= rx_lvl_hit_d;
      end
   end

   always_comb
   begin
      set_vec                     = '0;
      set_vec[ISCOL_BIT_SW]       = i_sw_trigger_en;
      set_vec[ISCOL_BIT_TXSTOP]   = i_stop_tx_req && i_evt.tx_halted;
      set_vec[ISCOL_BIT_RXSTOP]   = i_evt.rx_halted;
      set_vec[ISCOL_BIT_DROPHALF] = i_drop_cnt_inc && (i_drop_cnt == ISCOL_DROP_HALF_PRE);
      set_vec[ISCOL_BIT_TXDONE]   = i_evt.tx_buf_done;
      set_vec[ISCOL_BIT_RXDMA]    = i_evt.rx_dma_done;
      set_vec[ISCOL_BIT_TIMER]    = i_timer_dec && (i_timer_cnt == ISCOL_TIMER_ZERO);
      set_vec[ISCOL_BIT_POWER]    = i_evt.power_detect;
      set_vec[ISCOL_BIT_TXS_OVF]  = i_evt.tx_status_ovf;
      set_vec[ISCOL_BIT_OVERSIZE] = i_evt.rx_watchdog;
      set_vec[ISCOL_BIT_RX_ERR]   = i_evt.rx_error;
      set_vec[ISCOL_BIT_TX_ERR]   = i_evt.tx_error;
      set_vec[ISCOL_BIT_TXD_OVR]  = i_evt.tx_data_wr && i_evt.tx_data_full;
      set_vec[ISCOL_BIT_TXD_ROOM] = i_tx_free_blocks > i_tx_free_level;
      set_vec[ISCOL_BIT_TXS_FULL] = i_evt.tx_status_full;
      set_vec[ISCOL_BIT_TXS_LVL]  = tx_lvl_hit_d && !tx_lvl_hit_q;
      set_vec[ISCOL_BIT_RX_DROP]  = i_evt.rx_frame_drop;
      set_vec[ISCOL_BIT_RXS_FULL] = i_evt.rx_status_full;
      set_vec[ISCOL_BIT_RXS_LVL]  = rx_lvl_hit_d && !rx_lvl_hit_q;
      set_vec[ISCOL_BIT_GPIO0 +: 3] = i_evt.pin_event;
   end

   // Sticky write-one-clear flags, except the PHY mirror and reserved zeros; the mask never gates the set path
   genvar g;
   generate
      for (g = 0; g < 32; g++)
      begin : g_flag
         if (ISCOL_W1C_MASK[g])
         begin : g_w1c
            iscol_flag u_flag (
               .i_clk_sys (i_clk_sys),
               .i_rst_b   (i_rst_b),
               .i_set     (set_vec[g]),
               .i_clr     (wr_status && i_bus.wdata[g]),
               .o_flag    (flag_vec[g])
            );
         end
         else if (g == ISCOL_BIT_PHY)
         begin : g_ro
            assign flag_vec[g] = i_phy_event;
         end
         else
         begin : g_rsvd
            assign flag_vec[g] = 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         enable_q <= ISCOL_ENABLE_RESET;
      end
      else if (wr_enable)
      begin
         enable_q <= i_bus.wdata & ISCOL_IMPL_MASK;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_status     <= ISCOL_STATUS_RESET;
         o_master_irq <= 1'b0;
      end
      else
      begin
         o_status     <= flag_vec;
         // Registered OR of the enabled flags, so the line lags them by one cycle
         o_master_irq <= |(flag_vec & enable_q);
      end
   end

   // Wake only on a write to the byte test register, never on the event itself
   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_wake <= 1'b0;
      end
      else
      begin
         o_wake <= wr_byte_test && i_asleep;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_rdata <= '0;
      end
      else if (i_bus.rd)
      begin
         unique case (i_bus.addr)
            ISCOL_OFS_STATUS:    o_rdata <= flag_vec;
            ISCOL_OFS_ENABLE:    o_rdata <= enable_q;
            ISCOL_OFS_BYTE_TEST: o_rdata <= ISCOL_BYTE_TEST_VAL;
            default:             o_rdata <= '0;
         endcase
      end
   end

   property p_w1c_clears;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      (wr_status && i_bus.wdata[ISCOL_BIT_RX_ERR] && !set_vec[ISCOL_BIT_RX_ERR])
         |=> !flag_vec[ISCOL_BIT_RX_ERR];
   endproperty
   status_clear_a: assert property (p_w1c_clears) else $error("write-one did not clear");

   sw_flag_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_sw_trigger_en |=> flag_vec[ISCOL_BIT_SW]) else $error("software flag not set");

   drop_half_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_drop_cnt_inc && i_drop_cnt == ISCOL_DROP_HALF_PRE) |=> flag_vec[ISCOL_BIT_DROPHALF])
      else $error("drop half flag missed");

   timer_wrap_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_timer_dec && i_timer_cnt == ISCOL_TIMER_ZERO) |=> flag_vec[ISCOL_BIT_TIMER])
      else $error("timer wrap flag missed");

   phy_mirror_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_status[ISCOL_BIT_PHY] == $past(i_phy_event)) else $error("phy bit not mirrored");

   sequence s_power_set;
      i_evt.power_detect;
   endsequence
   sequence s_power_held;
      flag_vec[ISCOL_BIT_POWER] [*2];
   endsequence
   power_sticky_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      s_power_set ##1 !(wr_status && i_bus.wdata[ISCOL_BIT_POWER]) |-> s_power_held)
      else $error("power flag not sticky");

   wake_cause_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_wake |-> $past(wr_byte_test)) else $error("wake without byte test write");

   overrun_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_evt.tx_data_wr && i_evt.tx_data_full) |=> flag_vec[ISCOL_BIT_TXD_OVR])
      else $error("overrun flag missed");

   irq_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_master_irq == $past(|(flag_vec & enable_q))) else $error("master irq mismatch");

   rsvd_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (o_status & ~ISCOL_IMPL_MASK) == 32'h0000_0000) else $error("reserved bit set");

   write_zero_keep_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (wr_status && !i_bus.wdata[ISCOL_BIT_TX_ERR] && flag_vec[ISCOL_BIT_TX_ERR]) |=> flag_vec[ISCOL_BIT_TX_ERR])
      else $error("write of zero cleared a flag");

   status_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_bus.rd && i_bus.addr == ISCOL_OFS_STATUS) |=> (o_rdata == $past(flag_vec)))
      else $error("status read data wrong");

   txstop_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_evt.tx_halted && !i_stop_tx_req && !flag_vec[ISCOL_BIT_TXSTOP]) |=> !flag_vec[ISCOL_BIT_TXSTOP])
      else $error("stop flag set without request");

   rx_halt_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_evt.rx_halted |=> flag_vec[ISCOL_BIT_RXSTOP]) else $error("receive halt flag missed");

   power_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (wr_status && i_bus.wdata[ISCOL_BIT_POWER] && !i_evt.power_detect) |=> !flag_vec[ISCOL_BIT_POWER])
      else $error("power flag not cleared");

   overflow_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_evt.tx_status_ovf |=> flag_vec[ISCOL_BIT_TXS_OVF]) else $error("status overflow flag missed");

   oversize_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_evt.rx_watchdog |=> flag_vec[ISCOL_BIT_OVERSIZE]) else $error("oversize flag missed");

   tx_space_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_tx_free_blocks > i_tx_free_level) |=> flag_vec[ISCOL_BIT_TXD_ROOM])
      else $error("space flag missed");

   // The level flag must fire on the crossing itself, so the step is built in two parts
   sequence s_txs_below;
      i_tx_status_used < i_tx_status_level;
   endsequence
   sequence s_txs_reached;
      i_tx_status_used >= i_tx_status_level;
   endsequence
   txs_level_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      s_txs_below ##1 s_txs_reached |=> flag_vec[ISCOL_BIT_TXS_LVL])
      else $error("tx status level flag missed");

   drop_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_evt.rx_frame_drop |=> flag_vec[ISCOL_BIT_RX_DROP]) else $error("dropped frame flag missed");

   rxs_level_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_rx_status_used < i_rx_status_level) ##1 (i_rx_status_used >= i_rx_status_level)
      |=> flag_vec[ISCOL_BIT_RXS_LVL]) else $error("rx status level flag missed");

   pin_latch_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      |i_evt.pin_event |=> ((flag_vec[ISCOL_BIT_GPIO0 +: 3] & $past(i_evt.pin_event)) == $past(i_evt.pin_event)))
      else $error("pin event not latched");

   mask_free_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_evt.rx_error && !enable_q[ISCOL_BIT_RX_ERR]) |=> flag_vec[ISCOL_BIT_RX_ERR])
      else $error("masked event not recorded");

   enable_rsvd_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (enable_q & ~ISCOL_IMPL_MASK) == 32'h0000_0000) else $error("reserved enable bit set");

endmodule

// >>> hdl/iscol_pkg.sv
// Package for the interrupt status collector: offsets, bit positions, bus carriers
package iscol_pkg;
   localparam logic [7:0]  ISCOL_OFS_STATUS    = 8'h58;
   localparam logic [7:0]  ISCOL_OFS_ENABLE    = 8'h5c;
   localparam logic [7:0]  ISCOL_OFS_BYTE_TEST = 8'h64;
   localparam logic [31:0] ISCOL_STATUS_RESET  = 32'h0000_0000;
   localparam logic [31:0] ISCOL_ENABLE_RESET  = 32'h0000_0000;
   localparam logic [31:0] ISCOL_BYTE_TEST_VAL = 32'h8765_4321;
   localparam logic [31:0] ISCOL_DROP_HALF_PRE = 32'h7fff_ffff;
   localparam logic [15:0] ISCOL_TIMER_WRAP    = 16'hffff;
   localparam logic [15:0] ISCOL_TIMER_ZERO    = 16'h0000;
   localparam int          ISCOL_BIT_SW        = 31;
   localparam int          ISCOL_BIT_TXSTOP    = 25;
   localparam int          ISCOL_BIT_RXSTOP    = 24;
   localparam int          ISCOL_BIT_DROPHALF  = 23;
   localparam int          ISCOL_BIT_TXDONE    = 21;
   localparam int          ISCOL_BIT_RXDMA     = 20;
   localparam int          ISCOL_BIT_TIMER     = 19;
   localparam int          ISCOL_BIT_PHY       = 18;
   localparam int          ISCOL_BIT_POWER     = 17;
   localparam int          ISCOL_BIT_TXS_OVF   = 16;
   localparam int          ISCOL_BIT_OVERSIZE  = 15;
   localparam int          ISCOL_BIT_RX_ERR    = 14;
   localparam int          ISCOL_BIT_TX_ERR    = 13;
   localparam int          ISCOL_BIT_TXD_OVR   = 10;
   localparam int          ISCOL_BIT_TXD_ROOM  = 9;
   localparam int          ISCOL_BIT_TXS_FULL  = 8;
   localparam int          ISCOL_BIT_TXS_LVL   = 7;
   localparam int          ISCOL_BIT_RX_DROP   = 6;
   localparam int          ISCOL_BIT_RXS_FULL  = 4;
   localparam int          ISCOL_BIT_RXS_LVL   = 3;
   localparam int          ISCOL_BIT_GPIO0     = 0;
   // Implemented positions: everything else reads zero and ignores writes
   localparam logic [31:0] ISCOL_IMPL_MASK     = 32'h83bf_e7df;
   // Write-one-clear positions: the implemented set minus the PHY bit
   localparam logic [31:0] ISCOL_W1C_MASK      = 32'h83bb_e7df;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } iscol_bus_req_t;

   // Single-cycle event inputs from the engines, FIFOs and pins
   typedef struct packed {
      logic       tx_halted;
      logic       rx_halted;
      logic       tx_buf_done;
      logic       rx_dma_done;
      logic       power_detect;
      logic       tx_status_ovf;
      logic       rx_watchdog;
      logic       rx_error;
      logic       tx_error;
      logic       tx_data_wr;
      logic       tx_data_full;
      logic       tx_status_full;
      logic       rx_frame_drop;
      logic       rx_status_full;
      logic [2:0] pin_event;
   } iscol_events_t;
endpackage

// >>> hdl/iscol_flag.sv
// One sticky status flag with write-one-clear, set winning over clear
`timescale 1ns/1ps
module iscol_flag
   import iscol_pkg::*;
(
   input  wire logic i_clk_sys,
   input  wire logic i_rst_b,
   input  wire logic i_set,
   input  wire logic i_clr,
   output logic      o_flag
);
   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_flag <= 1'b0;
      end
      else if (i_set)
      begin
         o_flag <= 1'b1;
      end
      else if (i_clr)
      begin
         o_flag <= 1'b0;
      end
   end
endmodule

// >>> verif/iscol_host.sv
// Host processor model: issues whole-word register reads and writes
`timescale 1ns/1ps
module iscol_host
   import iscol_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic [31:0] i_rdata,
   output iscol_bus_req_t   o_bus
);
   initial o_bus = '0;

   // One-cycle strobe; released lines carry inverted values so stale data never looks valid
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(negedge i_clk_sys);
      o_bus <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      q = i_rdata;
      o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule

// >>> verif/tb.sv
// Self-checking bench for the interrupt status collector
`timescale 1ns/1ps
module tb;
   import iscol_pkg::*;
   logic           clk = 1'b0;
   logic           rst_b = 1'b0;
   iscol_bus_req_t bus;
   iscol_events_t  evt = '0;
   logic           sw_en = 0, stop_tx = 0, drop_inc = 0, tmr_dec = 0, phy = 0, asleep = 0;
   logic [31:0]    drop_cnt = '0, rdata, status, q;
   logic [15:0]    tmr_cnt = '0;
   logic [7:0]     tx_free = '0, tx_lvl = 8'h04, txs_used = '0, txs_lvl = 8'h03, rxs_used = '0, rxs_lvl = 8'h02;
   logic           irq, wake;
   int             err_total = 0, n_tests = 0, i;
   localparam logic [16:0] EV [16] = '{17'h10000, 17'h08000, 17'h04000, 17'h02000, 17'h01000, 17'h00800,
      17'h00400, 17'h00200, 17'h00100, 17'h000c0, 17'h00020, 17'h00010, 17'h00008, 17'h4, 17'h2, 17'h1};
   localparam int BT [16] = '{25, 24, 21, 20, 17, 16, 15, 14, 13, 10, 8, 6, 4, 2, 1, 0};

   always #4 clk = ~clk;

   iscol_host u_host (.i_clk_sys(clk), .i_rdata(rdata), .o_bus(bus));
   iscol_top #(.TX_FREE_W(8), .LEVEL_W(8)) DUT (.i_clk_sys(clk), .i_rst_b(rst_b), .i_bus(bus), .i_evt(evt),
      .i_sw_trigger_en(sw_en), .i_stop_tx_req(stop_tx), .i_drop_cnt_inc(drop_inc), .i_drop_cnt(drop_cnt),
      .i_timer_dec(tmr_dec), .i_timer_cnt(tmr_cnt), .i_phy_event(phy), .i_tx_free_blocks(tx_free),
      .i_tx_free_level(tx_lvl), .i_tx_status_used(txs_used), .i_tx_status_level(txs_lvl),
      .i_rx_status_used(rxs_used), .i_rx_status_level(rxs_lvl), .i_asleep(asleep), .o_rdata(rdata),
      .o_status(status), .o_master_irq(irq), .o_wake(wake));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      u_host.xfer(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, q);
   endtask

   task automatic pulse(input logic [16:0] ev);
      @(negedge clk);
      evt <= ev;
      @(negedge clk);
      evt <= '0;
   endtask

   // Flag must hold through a write of zero at its position, then clear on a write of one
   task automatic seen_clr(input int b);
      rd_chk(ISCOL_OFS_STATUS, 32'h1 << b);
      chk(status, 32'h1 << b);
      wr(ISCOL_OFS_STATUS, ~(32'h1 << b));
      rd_chk(ISCOL_OFS_STATUS, 32'h1 << b);
      wr(ISCOL_OFS_STATUS, 32'h1 << b);
      rd_chk(ISCOL_OFS_STATUS, 32'h0);
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      #200us;
      err_total++;
      summarize();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst_b <= 1'b1;
      rd_chk(ISCOL_OFS_STATUS, 32'h0);
      rd_chk(ISCOL_OFS_ENABLE, 32'h0);
      rd_chk(ISCOL_OFS_BYTE_TEST, 32'h8765_4321);
      rd_chk(8'h70, 32'h0);
      wr(ISCOL_OFS_STATUS, 32'hffff_ffff);
      rd_chk(ISCOL_OFS_STATUS, 32'h0);
      wr(ISCOL_OFS_ENABLE, 32'hffff_ffff);
      rd_chk(ISCOL_OFS_ENABLE, 32'h83bf_e7df);
      wr(ISCOL_OFS_ENABLE, 32'h0);
      $display("Test reset and map done");
      pulse(17'h10000);
      rd_chk(ISCOL_OFS_STATUS, 32'h0);
      stop_tx = 1'b1;
      pulse(17'h00040);
      rd_chk(ISCOL_OFS_STATUS, 32'h0);
      for (i = 0; i < 16; i++)
      begin
         pulse(EV[i]);
         seen_clr(BT[i]);
      end
      $display("Test event table done");
      @(negedge clk);
      sw_en <= 1'b1;
      @(negedge clk);
      sw_en <= 1'b0;
      seen_clr(31);
      @(negedge clk);
      drop_cnt <= 32'h7fff_fffe;
      drop_inc <= 1'b1;
      @(negedge clk);
      drop_inc <= 1'b0;
      rd_chk(ISCOL_OFS_STATUS, 32'h0);
      @(negedge clk);
      drop_cnt <= 32'h7fff_ffff;
      drop_inc <= 1'b1;
      @(negedge clk);
      drop_inc <= 1'b0;
      seen_clr(23);
      @(negedge clk);
      tmr_cnt <= 16'h0001;
      tmr_dec <= 1'b1;
      @(negedge clk);
      tmr_dec <= 1'b0;
      rd_chk(ISCOL_OFS_STATUS, 32'h0);
      @(negedge clk);
      tmr_cnt <= 16'h0000;
      tmr_dec <= 1'b1;
      @(negedge clk);
      tmr_dec <= 1'b0;
      seen_clr(19);
      $display("Test counters done");
      tx_free = 8'h04;
      rd_chk(ISCOL_OFS_STATUS, 32'h0);
      tx_free = 8'h05;
      @(negedge clk);
      tx_free <= 8'h00;
      seen_clr(9);
      txs_used = 8'h02;
      rxs_used = 8'h01;
      rd_chk(ISCOL_OFS_STATUS, 32'h0);
      txs_used = 8'h03;
      @(negedge clk);
      txs_used <= 8'h00;
      seen_clr(7);
      rxs_used = 8'h02;
      @(negedge clk);
      rxs_used <= 8'h00;
      seen_clr(3);
      phy = 1'b1;
      @(negedge clk);
      wr(ISCOL_OFS_STATUS, 32'h0004_0000);
      rd_chk(ISCOL_OFS_STATUS, 32'h0004_0000);
      phy = 1'b0;
      @(negedge clk);
      rd_chk(ISCOL_OFS_STATUS, 32'h0);
      $display("Test levels and mirror done");
      wr(ISCOL_OFS_ENABLE, 32'h0000_4000);
      pulse(17'h00200);
      rd_chk(ISCOL_OFS_STATUS, 32'h0000_4000);
      chk({31'h0, irq}, 32'h1);
      wr(ISCOL_OFS_STATUS, 32'h0000_4000);
      rd_chk(ISCOL_OFS_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      pulse(17'h00100);
      rd_chk(ISCOL_OFS_STATUS, 32'h0000_2000);
      chk({31'h0, irq}, 32'h0);
      wr(ISCOL_OFS_STATUS, 32'h0000_2000);
      asleep = 1'b1;
      pulse(17'h01000);
      chk({31'h0, wake}, 32'h0);
      wr(ISCOL_OFS_BYTE_TEST, 32'h0000_0000);
      chk({31'h0, wake}, 32'h1);
      seen_clr(17);
      $display("Test irq and wake done");
      summarize();
   end
endmodule
